// ### pif_pkg.sv
/*
 Package for the peripheral interrupt flag block: register offsets,
 field positions, reset values and masks.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package pif_pkg;

	// Register byte offsets on the AXI4-Lite slave
	localparam logic [7:0] OFF_FLAGS_ONE = 8'h00;
	localparam logic [7:0] OFF_FLAGS_TWO = 8'h04;
	localparam logic [7:0] OFF_ENABLE_ONE = 8'h08;
	localparam logic [7:0] OFF_ENABLE_TWO = 8'h0c;
	localparam logic [7:0] OFF_CONTROL = 8'h10;
	localparam logic [7:0] OFF_EDGE_SEL = 8'h14;
	localparam logic [7:0] OFF_STATUS = 8'h18;

	// Implemented bit masks of the two flag and enable registers
	localparam logic [7:0] MASK_ONE = 8'h7f;
	localparam logic [7:0] MASK_TWO = 8'h9f;

	// Reset values
	localparam logic [7:0] RST_FLAGS = 8'h00;
	localparam logic [7:0] RST_ENABLE = 8'h00;
	localparam logic [1:0] RST_CONTROL = 2'h0;
	localparam logic [5:0] RST_EDGE_SEL = 6'h15;

	// Control register fields
	localparam int CTL_GLOBAL = 0;
	localparam int CTL_PERIPH = 1;

	// Edge select fields (rise, fall pairs)
	localparam int SEL_OUT_OV_RISE = 0;
	localparam int SEL_OUT_OV_FALL = 1;
	localparam int SEL_IN_OV_RISE = 2;
	localparam int SEL_IN_OV_FALL = 3;
	localparam int SEL_IN_UV_RISE = 4;
	localparam int SEL_IN_UV_FALL = 5;

	// Flag positions in the second register
	localparam int BIT_OUT_OV = 3;
	localparam int BIT_IN_OV = 1;
	localparam int BIT_IN_UV = 0;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### edge_pick.sv
/*
 Transition detector for one monitor level with selectable edge.
 Assumes the level is synchronous to aclk.
*/
`timescale 1ns/1ps
module edge_pick (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Monitor level and edge selects
	input wire logic level,
	input wire logic rise_sel,
	input wire logic fall_sel,
	// One-cycle event
	output logic hit
);
	typedef struct packed {
		logic prev;
	} state_t;
	state_t s_q, s_d;

	// Previous level for edge compare
	always_comb begin
		s_d = s_q;
		s_d.prev = level;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// Track the live level so release shows no false edge
			s_q <= '{prev: level};
		end else begin
			s_q <= s_d;
		end
	end

	// Both selects set catches either edge
	assign hit = (rise_sel & level & ~s_q.prev) |
		(fall_sel & ~level & s_q.prev);
endmodule

// ### ctx_store.sv
/*
 Small memory holding the return program counter stack and the sixteen
 data bytes common to all banks. Read data is registered.
 Assumes a single writer and reader in the aclk domain.
*/
`timescale 1ns/1ps
module ctx_store #(
	parameter int DEPTH = 16,
	parameter int WIDTH = 13
) (
	// Clock
	input wire logic aclk,
	// Write port
	input wire logic wr_en,
	input wire logic [$clog2(DEPTH)-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	// Read port
	input wire logic [$clog2(DEPTH)-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] mem [DEPTH];

	// No reset on the array; contents are software owned
	always_ff @(posedge aclk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule

// ### peripheral_interrupt_flags.sv
/*
 Peripheral interrupt flags with enables, master gating, edge selects,
 return address stack and bank-common data bytes, over AXI4-Lite.
 Assumes event inputs are one-cycle pulses and monitor inputs are levels,
 all synchronous to aclk.
*/
// Behaviour
// - Flags set on their events regardless of any enable bit.
// - Flag one bit 7 and flag two bits 6-5 read zero.
// - Flag one bit 6 sets when a conversion completes.
// - Flag one bit 5 shows a pending serial collision.
// - Flag one bit 4 shows a pending serial port event.
// - Flag one bits 3 and 2 set on capture/compare two and one.
// - Flag one bit 1 sets on timer two period match, stays set.
// - Flag one bit 0 sets on timer one rollover, stays set.
// - Flag two bit 7 shows a pending desaturation event.
// - Flag two bit 4 sets on overtemperature.
// - Flag two bit 3 latches the selected output overvoltage edge.
// - Flag two bit 2 sets on gate supply undervoltage lockout.
// - Flag two bit 1 latches the selected input overvoltage edge.
// - Flag two bit 0 latches the selected input undervoltage edge.
// - Interrupt entry pushes only the return program counter.
// - Last sixteen data bytes are common to every bank.
// - No peripheral request reaches core without peripheral enable.
// - Each flag has an enable bit at the same position.
`timescale 1ns/1ps
module peripheral_interrupt_flags
	import pif_pkg::*;
#(
	parameter int PC_WIDTH = 13,
	parameter int STACK_DEPTH = 8
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Peripheral event pulses
	input wire logic conversion_done,
	input wire logic serial_collision,
	input wire logic serial_port_event,
	input wire logic capcomp_two_event,
	input wire logic capcomp_one_event,
	input wire logic timer_two_match,
	input wire logic timer_one_rollover,
	input wire logic desaturation_event,
	input wire logic overtemperature_event,
	input wire logic gate_supply_uvlo_event,
	// Protection monitor levels
	input wire logic output_ov_level,
	input wire logic input_ov_level,
	input wire logic input_uv_level,
	// Core interface
	output logic core_irq,
	input wire logic irq_entry,
	input wire logic irq_return,
	input wire logic [PC_WIDTH-1:0] return_pc,
	output logic [PC_WIDTH-1:0] resume_pc,
	// Core data access to bank-common bytes
	input wire logic common_wr,
	input wire logic [3:0] common_addr,
	input wire logic [7:0] common_wdata,
	output logic [7:0] common_rdata
);
	localparam int SP_W = $clog2(STACK_DEPTH);

	typedef struct packed {
		logic [7:0] flags_one;
		logic [7:0] flags_two;
		logic [7:0] enable_one;
		logic [7:0] enable_two;
		logic [1:0] control;
		logic [5:0] edge_sel;
		logic [SP_W-1:0] sp;
		logic aw_held;
		logic w_held;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic irq;
	} state_t;
	state_t s_q, s_d;

	logic ov_out_hit, ov_in_hit, uv_in_hit;
	logic [7:0] set_one, set_two;
	logic wr_fire, rd_fire;
	logic [7:0] wbyte;
	logic [PC_WIDTH-1:0] stack_rd;
	logic [SP_W-1:0] stack_waddr, stack_raddr;

	// Edge detectors for the three monitors
	edge_pick u_out_ov (
		.aclk(aclk),
		.aresetn(aresetn),
		.level(output_ov_level),
		.rise_sel(s_q.edge_sel[SEL_OUT_OV_RISE]),
		.fall_sel(s_q.edge_sel[SEL_OUT_OV_FALL]),
		.hit(ov_out_hit)
	);
	edge_pick u_in_ov (
		.aclk(aclk),
		.aresetn(aresetn),
		.level(input_ov_level),
		.rise_sel(s_q.edge_sel[SEL_IN_OV_RISE]),
		.fall_sel(s_q.edge_sel[SEL_IN_OV_FALL]),
		.hit(ov_in_hit)
	);
	edge_pick u_in_uv (
		.aclk(aclk),
		.aresetn(aresetn),
		.level(input_uv_level),
		.rise_sel(s_q.edge_sel[SEL_IN_UV_RISE]),
		.fall_sel(s_q.edge_sel[SEL_IN_UV_FALL]),
		.hit(uv_in_hit)
	);

	// Return address stack; only the PC is saved on entry
	assign stack_waddr = s_q.sp;
	assign stack_raddr = s_q.sp - SP_W'(1);
	ctx_store #(.DEPTH(STACK_DEPTH), .WIDTH(PC_WIDTH)) u_stack (
		.aclk(aclk),
		.wr_en(irq_entry),
		.wr_addr(stack_waddr),
		.wr_data(return_pc),
		.rd_addr(irq_return ? stack_raddr : stack_raddr - SP_W'(1)),
		.rd_data(stack_rd)
	);
	assign resume_pc = stack_rd;

	// Bank-common bytes: address carries no bank bits at all
	ctx_store #(.DEPTH(16), .WIDTH(8)) u_common (
		.aclk(aclk),
		.wr_en(common_wr),
		.wr_addr(common_addr),
		.wr_data(common_wdata),
		.rd_addr(common_addr),
		.rd_data(common_rdata)
	);

	// Event vectors in register bit order
	assign set_one = {1'b0, conversion_done, serial_collision,
		serial_port_event, capcomp_two_event, capcomp_one_event,
		timer_two_match, timer_one_rollover};
	assign set_two = {desaturation_event, 2'b00, overtemperature_event,
		ov_out_hit, gate_supply_uvlo_event, ov_in_hit,
		uv_in_hit};

	assign wr_fire = (s_q.aw_held | s_axi_awvalid) &
		(s_q.w_held | s_axi_wvalid) & ~s_q.bvalid;
	assign rd_fire = s_axi_arvalid & ~s_q.rvalid;
	assign wbyte = s_q.w_held ? s_q.wdata[7:0] : s_axi_wdata[7:0];

	// Next state: bus slave, flag latching and request gating
	always_comb begin
		logic [7:0] waddr;
		logic wen;
		waddr = s_q.aw_held ? s_q.awaddr : s_axi_awaddr;
		wen = wr_fire & (s_q.w_held ? s_q.wstrb[0] : s_axi_wstrb[0]);
		s_d = s_q;
		// Hold whichever half arrived first
		if (s_axi_awvalid & s_axi_awready & ~wr_fire) begin
			s_d.aw_held = 1'b1;
			s_d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid & s_axi_wready & ~wr_fire) begin
			s_d.w_held = 1'b1;
			s_d.wdata = s_axi_wdata;
			s_d.wstrb = s_axi_wstrb;
		end
		if (wr_fire) begin
			s_d.aw_held = 1'b0;
			s_d.w_held = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = RESP_OKAY;
			if (wen) begin
				case (waddr)
				OFF_FLAGS_ONE: s_d.flags_one = wbyte;
				OFF_FLAGS_TWO: s_d.flags_two = wbyte;
				OFF_ENABLE_ONE: s_d.enable_one = wbyte & MASK_ONE;
				OFF_ENABLE_TWO: s_d.enable_two = wbyte & MASK_TWO;
				OFF_CONTROL: s_d.control = wbyte[1:0];
				OFF_EDGE_SEL: s_d.edge_sel = wbyte[5:0];
				OFF_STATUS: s_d.bresp = RESP_OKAY;
				default: s_d.bresp = RESP_SLVERR;
				endcase
			end
		end else if (s_q.bvalid & s_axi_bready) begin
			s_d.bvalid = 1'b0;
		end
		// Hardware set wins over a software clear in the same cycle
		s_d.flags_one = (s_d.flags_one | set_one) & MASK_ONE;
		s_d.flags_two = (s_d.flags_two | set_two) & MASK_TWO;
		// Stack pointer wraps, as a hardware stack does
		if (irq_entry & ~irq_return) begin
			s_d.sp = s_q.sp + SP_W'(1);
		end else if (irq_return & ~irq_entry) begin
			s_d.sp = s_q.sp - SP_W'(1);
		end
		// Read channel
		if (rd_fire) begin
			s_d.rvalid = 1'b1;
			s_d.rresp = RESP_OKAY;
			case (s_axi_araddr)
			OFF_FLAGS_ONE: s_d.rdata = {24'h0, s_q.flags_one};
			OFF_FLAGS_TWO: s_d.rdata = {24'h0, s_q.flags_two};
			OFF_ENABLE_ONE: s_d.rdata = {24'h0, s_q.enable_one};
			OFF_ENABLE_TWO: s_d.rdata = {24'h0, s_q.enable_two};
			OFF_CONTROL: s_d.rdata = {30'h0, s_q.control};
			OFF_EDGE_SEL: s_d.rdata = {26'h0, s_q.edge_sel};
			OFF_STATUS: s_d.rdata = {31'h0, s_q.irq};
			default: begin
				s_d.rdata = 32'h0;
				s_d.rresp = RESP_SLVERR;
			end
			endcase
		end else if (s_q.rvalid & s_axi_rready) begin
			s_d.rvalid = 1'b0;
		end
		// Registered request to the core
		s_d.irq = s_q.control[CTL_GLOBAL] & s_q.control[CTL_PERIPH] &
			(|(s_q.flags_one & s_q.enable_one) |
			|(s_q.flags_two & s_q.enable_two));
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
			s_q.edge_sel <= RST_EDGE_SEL;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs
	assign s_axi_awready = ~s_q.aw_held & ~s_q.bvalid;
	assign s_axi_wready = ~s_q.w_held & ~s_q.bvalid;
	assign s_axi_bvalid = s_q.bvalid;
	assign s_axi_bresp = s_q.bresp;
	assign s_axi_arready = ~s_q.rvalid;
	assign s_axi_rvalid = s_q.rvalid;
	assign s_axi_rdata = s_q.rdata;
	assign s_axi_rresp = s_q.rresp;
	assign core_irq = s_q.irq;

	// Checks
	a_unimpl_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_q.flags_one[7] == 1'b0) && (s_q.flags_two[6:5] == 2'b00))
		else $error("unimplemented flag bit set");
	a_event_sets_one: assert property (@(posedge aclk)
		disable iff (!aresetn)
		(set_one != 8'h00) |=> ((s_q.flags_one & $past(set_one)) ==
		$past(set_one)))
		else $error("event did not set flag one");
	a_event_sets_two: assert property (@(posedge aclk)
		disable iff (!aresetn)
		(set_two != 8'h00) |=> ((s_q.flags_two & $past(set_two)) ==
		$past(set_two)))
		else $error("event did not set flag two");
	a_timer_flag_hold: assert property (@(posedge aclk)
		disable iff (!aresetn)
		s_q.flags_one[1:0] != 2'b00 && !wr_fire |=>
		(s_q.flags_one[1:0] & $past(s_q.flags_one[1:0])) ==
		$past(s_q.flags_one[1:0]))
		else $error("timer flag dropped without a write");
	a_out_ov_edge: assert property (@(posedge aclk) disable iff (!aresetn)
		s_q.edge_sel[1:0] == 2'b01 && $rose(output_ov_level) |=>
		s_q.flags_two[BIT_OUT_OV])
		else $error("output overvoltage rise missed");
	a_in_ov_fall: assert property (@(posedge aclk) disable iff (!aresetn)
		s_q.edge_sel[3:2] == 2'b10 && $fell(input_ov_level) |=>
		s_q.flags_two[BIT_IN_OV])
		else $error("input overvoltage fall missed");
	a_in_uv_edge: assert property (@(posedge aclk) disable iff (!aresetn)
		s_q.edge_sel[5:4] == 2'b01 && $rose(input_uv_level) |=>
		s_q.flags_two[BIT_IN_UV])
		else $error("input undervoltage rise missed");
	a_periph_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		!s_q.control[CTL_PERIPH] |=> !core_irq)
		else $error("request without peripheral enable");
	a_irq_or: assert property (@(posedge aclk) disable iff (!aresetn)
		s_q.control == 2'b11 && (|(s_q.flags_one & s_q.enable_one))
		|=> core_irq)
		else $error("enabled flag raised no request");
	a_stack_push: assert property (@(posedge aclk) disable iff (!aresetn)
		irq_entry && !irq_return |=> s_q.sp == $past(s_q.sp) + SP_W'(1))
		else $error("entry did not push");
endmodule

// ### core_model.sv
/*
 Core side model: answers a peripheral request with nested interrupt
 entries, then returns from each one.
 Assumes the block pushes on an entry strobe and pops on a return strobe.
*/
`timescale 1ns/1ps
module core_model #(
	parameter int NEST = 2,
	parameter int HOLD = 4
) (
	// Clock
	input wire logic aclk,
	// Request from the block, permission from the bench
	input wire logic core_irq,
	input wire logic serve,
	// Entry and return strobes with the pushed address
	output logic irq_entry,
	output logic irq_return,
	output logic [12:0] return_pc
);
	// Handler saves no high latch, as it uses no computed jumps
	initial begin
		irq_entry = 1'b0;
		irq_return = 1'b0;
		return_pc = 13'h0000;
		forever begin
			@(posedge aclk);
			if (serve && core_irq) begin
				// Entry held across the nested pushes, one per edge
				irq_entry <= 1'b1;
				for (int k = 0; k < NEST; k++) begin
					return_pc <= 13'($urandom);
					@(posedge aclk);
				end
				irq_entry <= 1'b0;
				// Address is stale outside entry: show its inverse
				return_pc <= ~return_pc;
				repeat (HOLD) @(posedge aclk);
				for (int k = 0; k < NEST; k++) begin
					irq_return <= 1'b1;
					@(posedge aclk);
					irq_return <= 1'b0;
					@(posedge aclk);
				end
				// One service per permission, or a held flag loops
				while (serve) @(posedge aclk);
			end
		end
	end
endmodule

// ### test_peripheral_interrupt_flags.sv
/*
 Self-checking bench for the peripheral interrupt flag block.
 Assumes pif_pkg, the design files and core_model are compiled first.
*/
`timescale 1ns/1ps
module test_peripheral_interrupt_flags;
	import pif_pkg::*;
	logic aclk, aresetn, awv, wv, bv, brd, arv, rv, rrd, awr, wr_r, arr;
	logic irq, entry, ret, serve, cwr, chk_pc;
	logic [7:0] awa, ara, cwd, crd;
	logic [31:0] wd, rdat, d;
	logic [1:0] bresp, rresp, r;
	logic [9:0] ev;
	logic [2:0] mon;
	logic [12:0] rpc, resume, exp_pc;
	logic [3:0] ca, ws;
	int num_errors = 0;
	int num_checks = 0;
	int m1 = 0, m2 = 0, npop = 0, pcq[$], mem[16];

	// Block under test
	peripheral_interrupt_flags peripheral_interrupt_flags_inst (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
		.s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_r),
		.s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(brd),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
		.s_axi_rready(rrd), .timer_one_rollover(ev[0]),
		.timer_two_match(ev[1]), .capcomp_one_event(ev[2]),
		.capcomp_two_event(ev[3]), .serial_port_event(ev[4]),
		.serial_collision(ev[5]), .conversion_done(ev[6]),
		.gate_supply_uvlo_event(ev[7]), .overtemperature_event(ev[8]),
		.desaturation_event(ev[9]), .output_ov_level(mon[0]),
		.input_ov_level(mon[1]), .input_uv_level(mon[2]),
		.core_irq(irq), .irq_entry(entry), .irq_return(ret),
		.return_pc(rpc), .resume_pc(resume), .common_wr(cwr),
		.common_addr(ca), .common_wdata(cwd), .common_rdata(crd));

	// Far side: core answering requests
	core_model core_model_inst (.aclk(aclk), .core_irq(irq), .serve(serve),
		.irq_entry(entry), .irq_return(ret), .return_pc(rpc));

	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	task automatic check(input string nm, input logic [31:0] s,
		input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask

	// Write: address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v,
		input logic [3:0] s);
		bit aw, w;
		@(posedge aclk);
		awa <= a;
		wd <= v;
		ws <= s;
		awv <= 1'b1;
		wv <= 1'b1;
		brd <= 1'b1;
		aw = 0;
		w = 0;
		repeat (40) begin
			@(posedge aclk);
			if (aw && w && bv) begin
				r = bresp;
				brd <= 1'b0;
				return;
			end
			if (!aw && awr) begin
				aw = 1;
				awv <= 1'b0;
			end
			if (!w && wr_r) begin
				w = 1;
				wv <= 1'b0;
			end
		end
		num_errors++;
	endtask

	// Read: rready held until rvalid is sampled
	task automatic rd(input logic [7:0] a);
		bit t;
		@(posedge aclk);
		ara <= a;
		arv <= 1'b1;
		rrd <= 1'b1;
		t = 0;
		repeat (40) begin
			@(posedge aclk);
			if (t && rv) begin
				d = rdat;
				r = rresp;
				rrd <= 1'b0;
				return;
			end
			if (!t && arr) begin
				t = 1;
				arv <= 1'b0;
			end
		end
		num_errors++;
	endtask

	// One-cycle event pulse, mirrored into the flag model
	task automatic pulse(input logic [9:0] m);
		@(posedge aclk);
		ev <= m;
		@(posedge aclk);
		ev <= 10'h000;
		m1 |= m[6:0];
		m2 |= {m[9], 2'b00, m[8], 1'b0, m[7], 2'b00};
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Stack model: pushes seen on entry, popped value due a cycle later
	always @(posedge aclk) begin
		chk_pc <= aresetn & ret;
		if (chk_pc) begin
			npop++;
			check("resume_pc", 32'(resume), 32'(exp_pc));
		end
		if (aresetn && entry) begin
			pcq.push_back(int'(rpc));
		end
		if (aresetn && ret && pcq.size() > 0) begin
			exp_pc <= 13'(pcq.pop_back());
		end
	end

	// Watchdog: 5000 cycles, about twenty-five times the couple of hundred cycles the tests need
	initial begin
		#500000;
		num_errors++;
		$display("watchdog expired");
		report_and_stop();
	end

	// Test sequence
	initial begin
		int e;
		void'($urandom(43));
		aresetn <= 1'b0;
		{awv, wv, brd, arv, rrd, cwr, serve} <= 7'h00;
		awa <= 8'h00;
		ara <= 8'h00;
		wd <= 32'h0;
		ws <= 4'hf;
		ev <= 10'h000;
		// Input undervoltage already present at power-up
		mon <= 3'b100;
		ca <= 4'h0;
		cwd <= 8'h00;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rd(OFF_FLAGS_TWO);
		check("flags_two reset", d, 32'(RST_FLAGS));
		rd(OFF_EDGE_SEL);
		check("edge_sel reset", d, 32'(RST_EDGE_SEL));
		check("core_irq reset", 32'(irq), 32'h0);
		$display("test reset done");
		// Events set flags with every enable off; timer flags stay
		e = $urandom;
		pulse(10'(e) | 10'h003);
		repeat (3) @(posedge aclk);
		rd(OFF_FLAGS_ONE);
		check("flags_one", d, 32'(m1));
		rd(OFF_FLAGS_TWO);
		check("flags_two", d, 32'(m2));
		check("core_irq masked", 32'(irq), 32'h0);
		wr(OFF_FLAGS_ONE, 32'hff, 4'hf);
		check("bresp", 32'(r), 32'(RESP_OKAY));
		rd(OFF_FLAGS_ONE);
		check("flags_one unimpl", d, 32'h7f);
		wr(OFF_FLAGS_TWO, 32'hff, 4'hf);
		rd(OFF_FLAGS_TWO);
		check("flags_two unimpl", d, 32'h9f);
		$display("test events done");
		// Stale flags cleared before any enable is set
		wr(OFF_FLAGS_ONE, 32'h0, 4'hf);
		wr(OFF_FLAGS_TWO, 32'h0, 4'hf);
		m1 = 0;
		m2 = 0;
		wr(OFF_ENABLE_ONE, 32'hff, 4'hf);
		rd(OFF_ENABLE_ONE);
		check("enable_one", d, 32'h7f);
		wr(OFF_ENABLE_TWO, 32'hff, 4'hf);
		rd(OFF_ENABLE_TWO);
		check("enable_two", d, 32'h9f);
		check("no stale request", 32'(irq), 32'h0);
		wr(OFF_CONTROL, 32'h1, 4'hf);
		pulse(10'h200);
		repeat (3) @(posedge aclk);
		check("irq global only", 32'(irq), 32'h0);
		wr(OFF_CONTROL, 32'h2, 4'hf);
		repeat (3) @(posedge aclk);
		check("irq periph only", 32'(irq), 32'h0);
		wr(OFF_CONTROL, 32'h3, 4'hf);
		repeat (3) @(posedge aclk);
		check("irq both enables", 32'(irq), 32'h1);
		rd(OFF_STATUS);
		check("status", d, 32'h1);
		wr(OFF_ENABLE_TWO, 32'h10, 4'hf);
		repeat (3) @(posedge aclk);
		check("irq other enable", 32'(irq), 32'h0);
		wr(OFF_ENABLE_TWO, 32'h80, 4'hf);
		repeat (3) @(posedge aclk);
		check("irq own enable", 32'(irq), 32'h1);
		$display("test enables done");
		// Core takes the request: nested entries, then returns
		@(posedge aclk);
		serve <= 1'b1;
		repeat (20) @(posedge aclk);
		serve <= 1'b0;
		check("pops", npop, 2);
		check("stack model empty", pcq.size(), 0);
		rd(OFF_FLAGS_TWO);
		check("desat flag held", d, 32'(m2));
		$display("test core done");
		// Monitor edges under rise selects, then fall selects
		wr(OFF_FLAGS_TWO, 32'h0, 4'hf);
		@(posedge aclk);
		mon <= 3'b000;
		repeat (3) @(posedge aclk);
		mon <= 3'b111;
		repeat (3) @(posedge aclk);
		rd(OFF_FLAGS_TWO);
		check("rise edges", d, 32'h0b);
		wr(OFF_EDGE_SEL, 32'h2a, 4'hf);
		wr(OFF_FLAGS_TWO, 32'h0, 4'hf);
		@(posedge aclk);
		mon <= 3'b000;
		repeat (3) @(posedge aclk);
		rd(OFF_FLAGS_TWO);
		check("fall edges", d, 32'h0b);
		wr(OFF_FLAGS_TWO, 32'h0, 4'hf);
		@(posedge aclk);
		mon <= 3'b111;
		repeat (3) @(posedge aclk);
		rd(OFF_FLAGS_TWO);
		check("rise ignored", d, 32'h0);
		$display("test monitors done");
		// Bank-common bytes written, then read back a cycle later
		for (int i = 0; i < 4; i++) begin
			@(posedge aclk);
			e = $urandom;
			ca <= 4'(i * 5);
			cwd <= 8'(e);
			cwr <= 1'b1;
			mem[i * 5] = e & 255;
		end
		@(posedge aclk);
		cwr <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			@(posedge aclk);
			ca <= 4'(i * 5);
			repeat (2) @(posedge aclk);
			check("common byte", 32'(crd), 32'(mem[i * 5]));
		end
		$display("test common done");
		// Strobe-less write ignored; unmapped offsets answer an error
		wr(OFF_ENABLE_ONE, 32'h0, 4'h0);
		check("bresp no strobe", 32'(r), 32'(RESP_OKAY));
		rd(OFF_ENABLE_ONE);
		check("enable kept", d, 32'h7f);
		wr(8'h40, 32'h1, 4'hf);
		check("bresp unmapped", 32'(r), 32'(RESP_SLVERR));
		rd(8'h40);
		check("rresp unmapped", 32'(r), 32'(RESP_SLVERR));
		check("rdata unmapped", d, 32'h0);
		$display("test bus errors done");
		// Reset in mid-run with flags set and monitors high
		pulse(10'h3ff);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		m1 = 0;
		m2 = 0;
		repeat (2) @(posedge aclk);
		check("core_irq after reset", 32'(irq), 32'h0);
		rd(OFF_FLAGS_ONE);
		check("flags_one after reset", d, 32'(m1));
		rd(OFF_FLAGS_TWO);
		check("flags_two after reset", d, 32'(m2));
		rd(OFF_CONTROL);
		check("control after reset", d, 32'(RST_CONTROL));
		$display("test mid reset done");
		report_and_stop();
	end
endmodule
